//--- rtl/ssra_slave.sv
`timescale 1ns/10ps
`default_nettype none
module ssra_slave
  import ssra_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
  input  wire logic       CLK_IN,
  input  wire logic       RSTN_IN,
  input  wire logic       CE_IN,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE_OUT,
  input  wire logic       ALERT_IN,
  output logic            ALERT_OUT,
  output logic            ALERT_OE_OUT,
  input  wire logic [7:0] MEAS_IN,
  output logic [7:0]      CONFIG_ONE_OUT,
  output logic [7:0]      STATUS_OUT
);

  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_prev;
  logic        sda_prev;
  ssra_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  tx_sh;
  logic        rw;
  logic        is_ara;
  logic        have_cmd;
  logic        have_data;
  logic        sda_oe;
  logic [7:0]  pointer;
  logic [7:0]  config_one;
  logic [7:0]  status;
  logic [7:0]  low_limit;
  logic [7:0]  high_limit;
  logic [7:0]  meas_q;
  logic        alert_oe;
  logic        tmo;

  // Both bus lines arrive from outside the clock domain.
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (CE_IN) begin
      scl_sync <= {scl_sync[0], SCL_IN};
      sda_sync <= {sda_sync[0], SDA_IN};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  wire scl        = scl_sync[1];
  wire sda        = sda_sync[1];
  wire scl_rise   = scl && !scl_prev;
  wire scl_fall   = !scl && scl_prev;
  wire sda_rise   = sda && !sda_prev;
  wire sda_fall   = !sda && sda_prev;
  wire start_det  = sda_fall && scl && scl_prev;
  wire stop_det   = sda_rise && scl && scl_prev;
  wire activity   = scl_rise || scl_fall || sda_rise || sda_fall;
  wire byte_done  = scl_fall && (bit_cnt == BITS_PER_BYTE);
  wire addr_hit   = (shreg[7:1] == OWN_ADDR);
  wire ara_hit    = (shreg[7:1] == ARA_ADDR) && shreg[0] && alert_oe;
  wire tmo_off    = config_one[CFG_BUS_TIMEOUT_OFF_BIT];
  wire timer_run  = (state != ST_IDLE) && !tmo_off;
  wire ack_end    = (state == ST_ACK) && scl_fall;
  wire cmd_take   = (state == ST_RX) && byte_done && !have_cmd;
  wire data_take  = (state == ST_RX) && byte_done && have_cmd && !have_data;
  wire status_clr = ack_end && rw && !is_ara && (pointer == REG_STATUS);

  wire [7:0] rd_data =
    (pointer == REG_MEAS)       ? meas_q :
    (pointer == REG_CONFIG_ONE) ? config_one :
    (pointer == REG_STATUS)     ? status :
    (pointer == REG_LOW_LIMIT)  ? low_limit :
    (pointer == REG_HIGH_LIMIT) ? high_limit : 8'h00;
  wire [7:0] tx_load = is_ara ? ARA_REPLY : rd_data;

  wire [7:0] set_mask = ({7'h00, meas_q < low_limit} << STATUS_LOW_BIT)
                      | ({7'h00, meas_q > high_limit} << STATUS_HIGH_BIT);
  wire [7:0] clr_mask = status_clr ? 8'hFF : 8'h00;
  wire [7:0] next_status = (status & ~clr_mask) | set_mask;

  ssra_idle_timer #(
    .LIMIT (TIMEOUT_CYCLES)
  ) u_idle_timer (
    .clk_in      (CLK_IN),
    .rstn_in     (RSTN_IN),
    .ce_in       (CE_IN),
    .run_in      (timer_run),
    .activity_in (activity),
    .expired_out (tmo)
  );

  // Bytes are sampled on SCL rising edges and driven after falling edges.
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      tx_sh     <= 8'h00;
      rw        <= 1'b0;
      is_ara    <= 1'b0;
      have_cmd  <= 1'b0;
      have_data <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (CE_IN) begin
      if (tmo) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_det) begin
        state     <= ST_ADDR;
        bit_cnt   <= 4'h0;
        sda_oe    <= 1'b0;
        have_cmd  <= 1'b0;
        have_data <= 1'b0;
      end else if (stop_det) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE, ST_WAIT: begin
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
              if (addr_hit || ara_hit) begin
                sda_oe <= 1'b1;
                rw     <= shreg[0];
                is_ara <= !addr_hit;
                state  <= ST_ACK;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rw) begin
                tx_sh  <= tx_load;
                sda_oe <= !tx_load[7];
                state  <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
              if (!have_data) begin
                sda_oe    <= 1'b1;
                have_cmd  <= 1'b1;
                have_data <= have_cmd;
                state     <= ST_ACK;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (!sda_oe && !sda) begin
                state <= ST_WAIT;
              end
            end else if (scl_fall) begin
              if (bit_cnt == BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                state  <= ST_MACK;
              end else begin
                tx_sh  <= {tx_sh[6:0], 1'b0};
                sda_oe <= !tx_sh[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              state <= ST_WAIT;
            end
          end
        endcase
      end
    end
  end

  // Status bits are sticky; a read of the status register clears them, but a live condition sets them again.
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      pointer    <= POINTER_RST;
      config_one <= CONFIG_ONE_RST;
      low_limit  <= LOW_LIMIT_RST;
      high_limit <= HIGH_LIMIT_RST;
      status     <= STATUS_RST;
      meas_q     <= 8'h00;
      alert_oe   <= 1'b0;
    end else if (CE_IN) begin
      meas_q   <= MEAS_IN;
      status   <= next_status;
      alert_oe <= |next_status;
      if (cmd_take) begin
        pointer <= shreg;
      end
      if (data_take && (pointer == REG_CONFIG_ONE)) begin
        config_one <= shreg;
      end
      if (data_take && (pointer == REG_LOW_LIMIT)) begin
        low_limit <= shreg;
      end
      if (data_take && (pointer == REG_HIGH_LIMIT)) begin
        high_limit <= shreg;
      end
    end
  end

  assign SDA_OUT        = 1'b0;
  assign SDA_OE_OUT     = sda_oe;
  assign ALERT_OUT      = 1'b0;
  assign ALERT_OE_OUT   = alert_oe;
  assign CONFIG_ONE_OUT = config_one;
  assign STATUS_OUT     = status;

  wire unused_alert = ALERT_IN;

  chk_timeout_release: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && tmo |=> !SDA_OE_OUT && (state == ST_IDLE))
    else $error("timeout did not release the bus");

  chk_stop_idle: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && stop_det && !start_det && !tmo |=> (state == ST_IDLE) && !SDA_OE_OUT)
    else $error("stop did not return to idle");

  chk_pointer_load: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && cmd_take && !tmo && !stop_det && !start_det |=> pointer == $past(shreg))
    else $error("first write byte not stored in pointer");

  chk_config_write: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && data_take && (pointer == REG_CONFIG_ONE) |=> config_one == $past(shreg) && pointer == $past(pointer))
    else $error("data byte not written to selected register");

  chk_ara_reply: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && ack_end && rw && is_ara && !tmo && !start_det && !stop_det
    |=> (tx_sh == ARA_REPLY) && (state == ST_TX))
    else $error("alert response did not load own address");

  chk_arb_loss: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (state == ST_TX) && scl_rise && !sda_oe && !sda
    |=> !SDA_OE_OUT ##1 (!SDA_OE_OUT || state != ST_TX))
    else $error("device kept driving after losing arbitration");

  chk_alert_cause: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (meas_q < low_limit) |=> ALERT_OE_OUT && status[STATUS_LOW_BIT])
    else $error("low limit violation did not raise alert");

  chk_alert_hold: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && status_clr && (meas_q > high_limit) |=> ALERT_OE_OUT)
    else $error("alert dropped while its cause remained");

  chk_timeout_off: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    tmo_off ##1 tmo_off |-> !tmo)
    else $error("timeout fired while disabled");

  chk_addr_nack: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (state == ST_ADDR) && byte_done && !addr_hit && !ara_hit && !tmo && !start_det && !stop_det
    |=> !SDA_OE_OUT [*2])
    else $error("foreign address was acknowledged");

  chk_ack_hold: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (state == ST_ACK) && !scl_fall && !tmo && !start_det && !stop_det |=> SDA_OE_OUT)
    else $error("acknowledge released before the clock fell");

  chk_tx_release: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (state == ST_TX) && scl_fall && (bit_cnt == BITS_PER_BYTE) && !tmo
    |=> !SDA_OE_OUT && (state == ST_MACK))
    else $error("data line not released after the read byte");

  chk_third_nack: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (state == ST_RX) && byte_done && have_data && !tmo
    |=> !SDA_OE_OUT && (state == ST_WAIT))
    else $error("byte after the data byte was acknowledged");

  chk_read_config: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && ack_end && rw && !is_ara && (pointer == REG_CONFIG_ONE) && !tmo
    |=> (tx_sh == $past(config_one)) && (state == ST_TX))
    else $error("read did not load the register at the pointer");

  chk_ara_gate: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (state == ST_ADDR) && byte_done && (shreg[7:1] == ARA_ADDR) && !ALERT_OE_OUT && !tmo
    |=> !SDA_OE_OUT)
    else $error("alert address acknowledged without alert");

  chk_idle_no_timeout: assert property (@(posedge CLK_IN) disable iff (!RSTN_IN)
    CE_IN && (state == ST_IDLE) |=> !tmo)
    else $error("timeout fired on an idle bus");

endmodule : ssra_slave
`default_nettype wire

//--- rtl/ssra_pkg.sv
// How it works
// - Send-byte is start, address with write, command; device acks address and command.
// - The command byte of a send-byte lands in the register pointer.
// - A repeated start right after the last ack begins a read with no stop.
// - Write-byte acks address, command and data, then writes data to the selected register.
// - Receive-byte acks a read address, drives one byte, master nacks then stops.
// - Receive-byte returns the register chosen by the pointer left by earlier writes.
// - With alert asserted, device acks the alert address and returns its own address.
// - Returned address bits arbitrate; a loser stops driving and keeps alert asserted.
// - Alert drops only once its causing condition has gone away.
// - After 35 ms without bus activity, release the data line and abandon the transfer; alert stays driven.
// - Bit 6 of config register 0x40 at 1 disables the timeout; reset value 0.
// - A value below its low limit or above its high limit sets status and alert.
// - Only the fixed address 0101110 is answered, and the alert address while alert is asserted.
// - The first written byte goes to the pointer; a second byte goes to a register.
package ssra_pkg;

  localparam logic [6:0] OWN_ADDR      = 7'h2E;
  localparam logic [6:0] ARA_ADDR      = 7'h0C;
  localparam logic [7:0] ARA_REPLY     = {OWN_ADDR, 1'b0};

  localparam logic [7:0] REG_MEAS       = 8'h21;
  localparam logic [7:0] REG_CONFIG_ONE = 8'h40;
  localparam logic [7:0] REG_STATUS     = 8'h41;
  localparam logic [7:0] REG_LOW_LIMIT  = 8'h46;
  localparam logic [7:0] REG_HIGH_LIMIT = 8'h47;

  localparam int         CFG_BUS_TIMEOUT_OFF_BIT = 6;
  localparam int         STATUS_LOW_BIT          = 0;
  localparam int         STATUS_HIGH_BIT         = 1;

  localparam logic [7:0] CONFIG_ONE_RST = 8'h00;
  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] LOW_LIMIT_RST  = 8'h00;
  localparam logic [7:0] HIGH_LIMIT_RST = 8'hFF;
  localparam logic [7:0] POINTER_RST    = 8'h00;

  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  localparam int         CLK_FREQ_HZ        = 100_000_000;
  localparam int         BUS_TIMEOUT_MS     = 35;
  localparam int         BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int         TMO_CNT_W          = 22;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_MACK,
    ST_WAIT
  } ssra_state_t;

endpackage : ssra_pkg

//--- rtl/ssra_idle_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ssra_idle_timer
  import ssra_pkg::*;
#(
  parameter int LIMIT = BUS_TIMEOUT_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  input  wire logic run_in,
  input  wire logic activity_in,
  output logic      expired_out
);

  logic [TMO_CNT_W-1:0] count;
  wire                  at_limit = (count == TMO_CNT_W'(LIMIT - 1));

  // The count restarts on every bus edge, so only a silent bus reaches the limit.
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      count       <= '0;
      expired_out <= 1'b0;
    end else if (ce_in) begin
      expired_out <= run_in && !activity_in && at_limit;
      if (!run_in || activity_in || at_limit) begin
        count <= '0;
      end else begin
        count <= count + TMO_CNT_W'(1);
      end
    end
  end

  chk_silence_only: assert property (@(posedge clk_in) disable iff (!rstn_in)
    expired_out |-> $past(run_in) && !$past(activity_in))
    else $error("timeout fired without a silent running bus");

endmodule : ssra_idle_timer
`default_nettype wire

//--- test/ssra_master.sv
`timescale 1ns/10ps
`default_nettype none
module ssra_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  logic ph = 1'b0;
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask : w
  // Data changes only while the clock is low; the line is sampled at the end of the high phase.
  task automatic bit_x(input logic b, output logic r);
    scl_out <= 1'b0;
    w(2);
    sda_oe_out <= ~b;
    w(4 + int'(ph));
    ph = ~ph;
    scl_out <= 1'b1;
    w(6);
    r = sda_in;
  endtask : bit_x
  // A read byte ends with the line released, which is the closing no-acknowledge.
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, r);
    a = ~r;
  endtask : xfer
  // Releases then pulls data for a start, or pulls then releases for a stop.
  task automatic frame(input logic first_oe, input logic last_oe);
    scl_out <= 1'b0;
    w(3);
    sda_oe_out <= first_oe;
    w(3);
    scl_out <= 1'b1;
    w(6);
    sda_oe_out <= last_oe;
    w(6);
  endtask : frame
  task automatic stall(input int n);
    scl_out <= 1'b0;
    w(2);
    sda_oe_out <= 1'b0;
    w(n);
  endtask : stall
endmodule : ssra_master
`default_nettype wire

//--- test/tb_smbus_slave_register_access.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_smbus_slave_register_access
  import ssra_pkg::*;
();
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  meas = 8'h00;
  logic        scl, m_oe, sda_o, sda_oe, alert_o, alert_oe, sda_line, alert_line_n;
  logic [7:0]  cfg_o, stat_o;
  logic [7:0]  mptr = 8'h00, mcfg = 8'h00, mlow = 8'h00, mhigh = 8'hFF, mstat = 8'h00;
  logic [31:0] seed = 32'h02E6;
  logic [7:0]  regs [$] = {REG_CONFIG_ONE, REG_LOW_LIMIT, REG_HIGH_LIMIT, REG_MEAS, 8'h10};
  int          failures = 0;
  int          total_checks = 0;
  assign sda_line = ~(m_oe | sda_oe);
  assign alert_line_n = ~alert_oe;
  initial forever #5 clk = ~clk;
  ssra_master u_m (.clk_in(clk), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(m_oe));
  ssra_slave #(.TIMEOUT_CYCLES(200)) uut (
    .CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .ALERT_IN(alert_line_n), .ALERT_OUT(alert_o),
    .ALERT_OE_OUT(alert_oe), .MEAS_IN(meas), .CONFIG_ONE_OUT(cfg_o), .STATUS_OUT(stat_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] cond();
    return {6'h00, meas > mhigh, meas < mlow};
  endfunction : cond
  function automatic logic [7:0] mval();
    case (mptr)
      REG_MEAS:       return meas;
      REG_CONFIG_ONE: return mcfg;
      REG_STATUS:     return mstat;
      REG_LOW_LIMIT:  return mlow;
      REG_HIGH_LIMIT: return mhigh;
      default:        return 8'h00;
    endcase
  endfunction : mval
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [7:0] p, d, input int n, input logic stp);
    logic       a;
    logic [7:0] q;
    u_m.frame(1'b0, 1'b1);
    u_m.xfer({OWN_ADDR, 1'b0}, q, a);
    `CHK(a, 1'b1)
    u_m.xfer(p, q, a);
    `CHK(a, 1'b1)
    mptr = p;
    if (n > 1) begin
      u_m.xfer(d, q, a);
      `CHK(a, 1'b1)
      case (p)
        REG_CONFIG_ONE: mcfg = d;
        REG_LOW_LIMIT:  mlow = d;
        REG_HIGH_LIMIT: mhigh = d;
        default: ;
      endcase
    end
    if (n > 2) begin
      u_m.xfer(~d, q, a);
      `CHK(a, 1'b0)
    end
    if (stp) u_m.frame(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    mstat |= cond();
  endtask : wr
  task automatic rd();
    logic       a;
    logic [7:0] q, e;
    e = mval();
    u_m.frame(1'b0, 1'b1);
    u_m.xfer({OWN_ADDR, 1'b1}, q, a);
    `CHK(a, 1'b1)
    u_m.xfer(8'hFF, q, a);
    `CHK(q, e)
    u_m.frame(1'b1, 1'b0);
    if (mptr == REG_STATUS) mstat = cond();
    `CHK(alert_oe, mstat != 8'h00)
  endtask : rd
  // The master drives a rival address byte while reading; the lower of the two must win.
  task automatic ara(input logic [7:0] rival);
    logic       a;
    logic [7:0] q;
    u_m.frame(1'b0, 1'b1);
    u_m.xfer({ARA_ADDR, 1'b1}, q, a);
    `CHK(a, mstat != 8'h00)
    if (a === 1'b1) begin
      u_m.xfer(rival, q, a);
      `CHK(q, (rival < ARA_REPLY) ? rival : ARA_REPLY)
    end
    u_m.frame(1'b1, 1'b0);
    `CHK(alert_oe, mstat != 8'h00)
  endtask : ara
  // Stops the clock during the address acknowledge and looks whether the device lets go.
  task automatic tmo(input logic dis);
    logic       r;
    logic [7:0] c, aw;
    c = 8'h00;
    c[CFG_BUS_TIMEOUT_OFF_BIT] = dis;
    aw = {OWN_ADDR, 1'b0};
    wr(REG_CONFIG_ONE, c, 2, 1'b1);
    u_m.frame(1'b0, 1'b1);
    for (int i = 7; i >= 0; i--) u_m.bit_x(aw[i], r);
    u_m.stall(300);
    `CHK(sda_oe, dis)
    u_m.bit_x(1'b1, r);
    u_m.frame(1'b1, 1'b0);
    `CHK(sda_oe, 1'b0)
    `CHK(cfg_o, mcfg)
  endtask : tmo
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    logic       a;
    logic [7:0] q;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(cfg_o, CONFIG_ONE_RST)
    `CHK(stat_o, STATUS_RST)
    ara(8'hFF);
    seed = lfsr(seed);
    meas <= seed[7:0];
    wr(REG_MEAS, 8'h00, 1, 1'b0);
    rd();
    meas <= 8'hFF;
    foreach (regs[i]) begin
      seed = lfsr(seed);
      wr(regs[i], seed[7:0], 2, 1'b1);
      rd();
    end
    u_m.frame(1'b0, 1'b1);
    u_m.xfer({7'h2F, 1'b0}, q, a);
    `CHK(a, 1'b0)
    u_m.frame(1'b1, 1'b0);
    wr(REG_LOW_LIMIT, 8'h00, 3, 1'b1);
    rd();
    tmo(1'b0);
    tmo(1'b1);
    wr(REG_HIGH_LIMIT, 8'h08, 2, 1'b1);
    wr(REG_LOW_LIMIT, 8'h80, 2, 1'b1);
    meas <= 8'h10;
    repeat (4) @(posedge clk);
    mstat |= cond();
    `CHK(alert_oe, 1'b1)
    ara(8'hFF);
    ara(8'h5A);
    wr(REG_STATUS, 8'h00, 1, 1'b0);
    rd();
    meas <= 8'h90;
    repeat (4) @(posedge clk);
    rd();
    wr(REG_HIGH_LIMIT, 8'hFF, 2, 1'b1);
    wr(REG_STATUS, 8'h00, 1, 1'b0);
    rd();
    // With the clock enable low a violating value must not reach the status register.
    ce <= 1'b0;
    meas <= 8'h10;
    repeat (8) @(posedge clk);
    `CHK(stat_o, 8'h00)
    `CHK(alert_oe, 1'b0)
    ce <= 1'b1;
    meas <= 8'h90;
    repeat (4) @(posedge clk);
    `CHK(stat_o, mstat)
    `CHK(sda_o, 1'b0)
    `CHK(alert_o, 1'b0)
    tally_and_finish();
  end
endmodule : tb_smbus_slave_register_access
`default_nettype wire
